// ---- hdl/mms_pkg.sv ----
package mms_pkg;

	// Outbound line positions on the A bus
	localparam int A_DOUT0 = 1;
	localparam int A_DOUT1 = 4;
	localparam int A_DOUT2 = 7;
	localparam int A_EOUT  = 3;
	localparam int A_CLK0  = 2;
	localparam int A_CLK1  = 6;
	localparam int A_CLK1B = 5;

	// Inbound line positions on the B bus
	localparam int B_DIN0  = 1;
	localparam int B_DIN1  = 4;
	localparam int B_DIN2  = 7;
	localparam int B_CLKI0 = 3;
	localparam int B_CLKI1 = 6;
	localparam int B_RSP0  = 2;
	localparam int B_RSP1  = 5;

	// Control out states as {select, master, sync}
	localparam logic [2:0] CTL_IDLE      = 3'h0;
	localparam logic [2:0] CTL_MAINT     = 3'h1;
	localparam logic [2:0] CTL_RESETSEL1 = 3'h4;

	// Voted signal slots in the slave
	localparam int V_DOUT = 0;
	localparam int V_EOUT = 1;
	localparam int V_CLK  = 2;
	localparam int V_SEL  = 3;
	localparam int V_MST  = 4;
	localparam int V_SYNC = 5;
	localparam int V_NUM  = 6;

	// Sizes and counts
	localparam int DESER_W    = 8;
	localparam int STEP_TICKS = 4;
	localparam int LINK_HALF  = 2;

	// Reset values
	localparam logic [7:0] DESER_RST = 8'h00;

	typedef enum logic [3:0] {
		S_NORMAL  = 4'b0001,
		S_MAINT   = 4'b0010,
		S_RESET   = 4'b0100,
		S_ISOLATE = 4'b1000
	} mms_slv_state_e;

	typedef enum logic [7:0] {
		M_READY = 8'b0000_0001,
		M_CMD   = 8'b0000_0010,
		M_DIRLO = 8'b0000_0100,
		M_ENA   = 8'b0000_1000,
		M_CLKHI = 8'b0001_0000,
		M_CLKLO = 8'b0010_0000,
		M_ENDF  = 8'b0100_0000,
		M_IDLE  = 8'b1000_0000
	} mms_mst_state_e;

	typedef enum logic [2:0] {
		OP_MAINT    = 3'h0,
		OP_WRITE    = 3'h1,
		OP_IDLE     = 3'h2,
		OP_RESETSEL = 3'h3,
		OP_NORMAL   = 3'h4
	} mms_op_e;

endpackage

// ---- hdl/mms_link_if.sv ----
`timescale 1ns/10ps
interface mms_link_if;
	logic       link_clk;
	logic       select_out;
	logic       master_out;
	logic       sync_out;
	logic [7:0] bus_a;
	logic       bus_a_par;
	logic [7:0] bus_b;
	logic       bus_b_par;
	logic       slv_drv_oe;

	modport master (
		output link_clk,
		output select_out,
		output master_out,
		output sync_out,
		output bus_a,
		output bus_a_par,
		input  bus_b,
		input  bus_b_par
	);

	modport slave (
		input  link_clk,
		input  select_out,
		input  master_out,
		input  sync_out,
		input  bus_a,
		input  bus_a_par,
		output slv_drv_oe
	);
endinterface

// ---- hdl/mms_vote_sync.sv ----
`timescale 1ns/10ps
module mms_vote_sync #(
	parameter int N = 1
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [3*N-1:0] lines,
	output logic [N-1:0]      level
);
	logic [N-1:0] s1_q;
	logic [N-1:0] s2_q;
	logic [N-1:0] s3_q;
	logic [N-1:0] level_q;

	for (genvar i = 0; i < N; i++) begin : g_bit
		logic vote;
		// Two of three on static levels
		assign vote = (lines[3*i] & lines[3*i+1]) | (lines[3*i] & lines[3*i+2]) |
			(lines[3*i+1] & lines[3*i+2]);

		always_ff @(posedge clk or posedge reset) begin
			if (reset) begin
				s1_q[i]    <= 1'b0;
				s2_q[i]    <= 1'b0;
				s3_q[i]    <= 1'b0;
				level_q[i] <= 1'b0;
			end else begin
				s1_q[i] <= vote;
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (s2_q[i] == s3_q[i]) begin
					level_q[i] <= s3_q[i];
				end
			end
		end
	end

	assign level = level_q;
endmodule // mms_vote_sync

// ---- hdl/mms_slave.sv ----
`timescale 1ns/10ps
module mms_slave
	import mms_pkg::*;
#(
	parameter int DESER_WIDTH = mms_pkg::DESER_W,
	parameter bit MM2_EN      = 1'b1
) (
	input  wire logic                   reset,
	input  wire logic                   sys_clk,
	mms_link_if.slave                   link,
	output logic                        mm_reset,
	output logic                        drv_released,
	output logic                        maint_active,
	output logic                        wr_valid,
	output logic [DESER_WIDTH-1:0]      wr_data
);
	import mms_pkg::*;

	logic [V_NUM-1:0]       v;
	logic [3*V_NUM-1:0]     raw_lines;
	logic [2:0]             ctl_v;
	logic                   is_maint;
	logic                   is_rsel1;
	logic                   sync_fall;
	logic                   rst_req;
	logic                   clk_rise;
	logic                   eout_fall;

	mms_slv_state_e         state_q;
	logic                   sync_prev_q;
	logic                   clk_prev_q;
	logic                   eout_prev_q;
	logic                   dir_write_q;
	logic [DESER_WIDTH-1:0] deser_q;
	logic [DESER_WIDTH-1:0] frame_word_q;
	logic                   wr_tog_q;
	logic                   drv_oe_q;
	logic                   rst_lvl_q;
	logic                   maint_lvl_q;

	logic [2:0]             lvl_sync;
	logic                   tog1_q;
	logic                   tog2_q;
	logic                   tog3_q;
	logic                   wr_valid_q;
	logic [DESER_WIDTH-1:0] wr_data_q;

	// Data out and clock lines triplicated, other lines copied thrice; each group voted then synchronised
	assign raw_lines = {
		{3{link.sync_out}},
		{3{link.master_out}},
		{3{link.select_out}},
		link.bus_a_par, link.bus_a[A_CLK1], link.bus_a[A_CLK0],
		{3{link.bus_a[A_EOUT]}},
		link.bus_a[A_DOUT2], link.bus_a[A_DOUT1], link.bus_a[A_DOUT0]
	};

	// Three stage synchroniser behind the vote
	mms_vote_sync #(
		.N(V_NUM)
	) u_vote (
		.clk   (link.link_clk),
		.reset (reset),
		.lines (raw_lines),
		.level (v)
	);

	// Control state decode
	assign ctl_v     = {v[V_SEL], v[V_MST], v[V_SYNC]};
	assign is_maint  = (ctl_v == CTL_MAINT);
	assign is_rsel1  = (ctl_v == CTL_RESETSEL1);
	assign sync_fall = sync_prev_q & ~v[V_SYNC];
	assign clk_rise  = v[V_CLK] & ~clk_prev_q;
	assign eout_fall = eout_prev_q & ~v[V_EOUT];

	// Reset condition depends on mode
	assign rst_req = MM2_EN ? (v[V_DOUT] & v[V_EOUT]) : v[V_DOUT];

	// Edge history on the link clock
	always_ff @(posedge link.link_clk or posedge reset) begin
		if (reset) begin
			sync_prev_q <= 1'b0;
			clk_prev_q  <= 1'b0;
			eout_prev_q <= 1'b0;
		end else begin
			sync_prev_q <= v[V_SYNC];
			clk_prev_q  <= v[V_CLK];
			eout_prev_q <= v[V_EOUT];
		end
	end

	// Maintenance state machine
	always_ff @(posedge link.link_clk or posedge reset) begin
		if (reset) begin
			state_q <= S_NORMAL;
		end else begin
			unique case (state_q)
				S_NORMAL: begin
					if (is_maint) begin
						state_q <= S_MAINT;
					end
				end
				S_MAINT: begin
					if (!is_maint) begin
						if (sync_fall && rst_req) begin
							state_q <= S_RESET;
						end else begin
							state_q <= S_NORMAL;
						end
					end
				end
				S_RESET: begin
					if (is_maint) begin
						state_q <= S_MAINT;
					end else if (!rst_req) begin
						state_q <= S_ISOLATE;
					end
				end
				S_ISOLATE: begin
					if (is_maint) begin
						state_q <= S_MAINT;
					end else if (is_rsel1) begin
						state_q <= S_NORMAL;
					end
				end
				default: begin
					state_q <= S_NORMAL;
				end
			endcase
		end
	end

	// Drivers follow the state; released at once when MAINT is seen
	always_ff @(posedge link.link_clk or posedge reset) begin
		if (reset) begin
			drv_oe_q <= 1'b1;
		end else begin
			drv_oe_q <= (state_q == S_NORMAL) && !is_maint;
		end
	end

	// Reset level while the reset state holds
	always_ff @(posedge link.link_clk or posedge reset) begin
		if (reset) begin
			rst_lvl_q   <= 1'b0;
			maint_lvl_q <= 1'b0;
		end else begin
			rst_lvl_q   <= (state_q == S_RESET) && rst_req;
			maint_lvl_q <= (state_q == S_MAINT);
		end
	end

	// Direction from a clock pulse before enable rises
	always_ff @(posedge link.link_clk or posedge reset) begin
		if (reset) begin
			dir_write_q <= 1'b0;
		end else if (clk_rise && !v[V_EOUT]) begin
			dir_write_q <= v[V_DOUT];
		end
	end

	// Deserialiser, loaded without regard to selection
	always_ff @(posedge link.link_clk or posedge reset) begin
		if (reset) begin
			deser_q <= DESER_WIDTH'(DESER_RST);
		end else if ((state_q == S_MAINT) && clk_rise && v[V_EOUT] && dir_write_q) begin
			deser_q <= {deser_q[DESER_WIDTH-2:0], v[V_DOUT]};
		end
	end

	// Frame end captures the word and flips the event toggle
	always_ff @(posedge link.link_clk or posedge reset) begin
		if (reset) begin
			frame_word_q <= DESER_WIDTH'(DESER_RST);
			wr_tog_q     <= 1'b0;
		end else if ((state_q == S_MAINT) && eout_fall && dir_write_q) begin
			frame_word_q <= deser_q;
			wr_tog_q     <= ~wr_tog_q;
		end
	end

	assign link.slv_drv_oe = drv_oe_q;

	// Levels into the system clock, three stages, counted once two agree
	mms_vote_sync #(
		.N(3)
	) u_lvl_sync (
		.clk   (sys_clk),
		.reset (reset),
		.lines ({{3{maint_lvl_q}}, {3{~drv_oe_q}}, {3{rst_lvl_q}}}),
		.level (lvl_sync)
	);

	// Write word handed over by toggle
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tog1_q     <= 1'b0;
			tog2_q     <= 1'b0;
			tog3_q     <= 1'b0;
			wr_valid_q <= 1'b0;
			wr_data_q  <= DESER_WIDTH'(DESER_RST);
		end else begin
			tog1_q     <= wr_tog_q;
			tog2_q     <= tog1_q;
			tog3_q     <= tog2_q;
			wr_valid_q <= tog2_q ^ tog3_q;
			if (tog2_q ^ tog3_q) begin
				wr_data_q <= frame_word_q;
			end
		end
	end

	assign mm_reset     = lvl_sync[0];
	assign drv_released = lvl_sync[1];
	assign maint_active = lvl_sync[2];
	assign wr_valid     = wr_valid_q;
	assign wr_data      = wr_data_q;
endmodule // mms_slave

// ---- hdl/mms_master.sv ----
`timescale 1ns/10ps
module mms_master
	import mms_pkg::*;
#(
	parameter int DESER_WIDTH = mms_pkg::DESER_W,
	parameter int HALF_CYC    = mms_pkg::LINK_HALF,
	parameter int STEP_CNT    = mms_pkg::STEP_TICKS
) (
	input  wire logic                   reset,
	input  wire logic                   sys_clk,
	mms_link_if.master                  link,
	input  wire logic                   cmd_valid,
	input  wire mms_pkg::mms_op_e       cmd_op,
	input  wire logic [DESER_WIDTH-1:0] cmd_data,
	input  wire logic                   cmd_reset,
	output logic                        cmd_ready,
	output logic                        mm_data_in,
	output logic                        mm_clk_in,
	output logic                        mm_resp_in
);
	import mms_pkg::*;

	localparam int HW = $clog2(HALF_CYC + 1);
	localparam int SW = $clog2(STEP_CNT + 1);
	localparam int BW = $clog2(DESER_WIDTH + 1);

	logic [HW-1:0]          div_q;
	logic                   lclk_q;
	logic [SW-1:0]          scnt_q;
	logic                   tick;
	logic                   step;
	mms_mst_state_e         state_q;
	mms_op_e                op_q;
	logic [DESER_WIDTH-1:0] data_q;
	logic [BW-1:0]          bits_q;
	logic                   rst_sel_q;
	logic                   rdy_q;
	logic [2:0]             ctl_q;
	logic                   dout_q;
	logic                   eout_q;
	logic                   mclk_q;
	logic [2:0]             ctl_out_q;
	logic [7:0]             bus_a_q;
	logic                   par_q;
	logic [2:0]             in_lvl;

	// Link clock divider; lines move one system clock after its falling edge
	assign tick = (div_q == HW'(HALF_CYC - 1)) && lclk_q;
	assign step = tick && (scnt_q == SW'(STEP_CNT - 1));

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			div_q  <= '0;
			lclk_q <= 1'b0;
		end else if (div_q == HW'(HALF_CYC - 1)) begin
			div_q  <= '0;
			lclk_q <= ~lclk_q;
		end else begin
			div_q <= div_q + HW'(1);
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			scnt_q <= '0;
		end else if (step) begin
			scnt_q <= '0;
		end else if (tick) begin
			scnt_q <= scnt_q + SW'(1);
		end
	end

	// Sequencer
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state_q   <= M_READY;
			op_q      <= OP_NORMAL;
			data_q    <= '0;
			bits_q    <= '0;
			rst_sel_q <= 1'b0;
			rdy_q     <= 1'b1;
		end else begin
			unique case (state_q)
				M_READY: begin
					if (cmd_valid) begin
						op_q      <= cmd_op;
						data_q    <= cmd_data;
						bits_q    <= BW'(DESER_WIDTH);
						rst_sel_q <= cmd_reset;
						rdy_q     <= 1'b0;
						state_q   <= M_CMD;
					end
				end
				M_CMD: begin
					if (step) begin
						if (op_q == OP_WRITE) begin
							state_q <= M_DIRLO;
						end else if (op_q == OP_IDLE) begin
							state_q <= M_IDLE;
						end else begin
							state_q <= M_READY;
							rdy_q   <= 1'b1;
						end
					end
				end
				M_DIRLO: if (step) state_q <= M_ENA;
				M_ENA:   if (step) state_q <= M_CLKHI;
				M_CLKHI: if (step) state_q <= M_CLKLO;
				M_CLKLO: begin
					if (step) begin
						data_q <= data_q << 1;
						bits_q <= bits_q - BW'(1);
						state_q <= (bits_q == BW'(1)) ? M_ENDF : M_CLKHI;
					end
				end
				M_ENDF, M_IDLE: begin
					if (step) begin
						state_q <= M_READY;
						rdy_q   <= 1'b1;
					end
				end
				default: state_q <= M_READY;
			endcase
		end
	end

	// Line levels per step
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctl_q  <= CTL_IDLE;
			dout_q <= 1'b0;
			eout_q <= 1'b0;
			mclk_q <= 1'b0;
		end else if (step) begin
			unique case (state_q)
				M_CMD: begin
					unique case (op_q)
						OP_WRITE: begin
							dout_q <= 1'b1;
							mclk_q <= 1'b1;
						end
						OP_IDLE: begin
							dout_q <= rst_sel_q;
							eout_q <= rst_sel_q;
						end
						OP_MAINT: begin
							ctl_q  <= CTL_MAINT;
							dout_q <= 1'b0;
							eout_q <= 1'b0;
						end
						OP_RESETSEL: begin
							ctl_q  <= CTL_RESETSEL1;
							dout_q <= 1'b0;
							eout_q <= 1'b0;
						end
						default: ctl_q <= CTL_IDLE;
					endcase
				end
				M_DIRLO: mclk_q <= 1'b0;
				M_ENA: begin
					eout_q <= 1'b1;
					dout_q <= data_q[DESER_WIDTH-1];
				end
				M_CLKHI: mclk_q <= 1'b1;
				M_CLKLO: begin
					mclk_q <= 1'b0;
					dout_q <= data_q[DESER_WIDTH-2];
				end
				M_ENDF: begin
					eout_q <= 1'b0;
					dout_q <= 1'b0;
				end
				M_IDLE: ctl_q <= CTL_IDLE;
				default: ctl_q <= ctl_q;
			endcase
		end
	end

	// Pin registers; data out in three copies, clock out in four with parity, enable out in one
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ctl_out_q <= CTL_IDLE;
			bus_a_q   <= 8'h00;
			par_q     <= 1'b0;
		end else begin
			ctl_out_q        <= ctl_q;
			bus_a_q          <= 8'h00;
			bus_a_q[A_DOUT0] <= dout_q;
			bus_a_q[A_DOUT1] <= dout_q;
			bus_a_q[A_DOUT2] <= dout_q;
			bus_a_q[A_EOUT]  <= eout_q;
			bus_a_q[A_CLK0]  <= mclk_q;
			bus_a_q[A_CLK1]  <= mclk_q;
			bus_a_q[A_CLK1B] <= mclk_q;
			par_q            <= mclk_q;
		end
	end

	// Inbound lines voted on the system clock
	mms_vote_sync #(
		.N(3)
	) u_in_vote (
		.clk   (sys_clk),
		.reset (reset),
		.lines ({link.bus_b_par, link.bus_b[B_RSP1], link.bus_b[B_RSP0],
			1'b0, link.bus_b[B_CLKI1], link.bus_b[B_CLKI0],
			link.bus_b[B_DIN2], link.bus_b[B_DIN1], link.bus_b[B_DIN0]}),
		.level (in_lvl)
	);

	assign link.link_clk   = lclk_q;
	assign link.select_out = ctl_out_q[2];
	assign link.master_out = ctl_out_q[1];
	assign link.sync_out   = ctl_out_q[0];
	assign link.bus_a      = bus_a_q;
	assign link.bus_a_par  = par_q;
	assign cmd_ready       = rdy_q;
	assign mm_data_in      = in_lvl[0];
	assign mm_clk_in       = in_lvl[1];
	assign mm_resp_in      = in_lvl[2];
endmodule // mms_master

// ---- test/mms_link_checker.sv ----
`timescale 1ns/10ps
module mms_link_checker
	import mms_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       reset,
	input wire logic       link_clk,
	input wire logic       select_out,
	input wire logic       master_out,
	input wire logic       sync_out,
	input wire logic [7:0] bus_a,
	input wire logic       bus_a_par,
	input wire logic       slv_drv_oe
);
	logic [2:0] ctl;
	assign ctl = {select_out, master_out, sync_out};

	clk_copy_a: assert property (@(posedge sys_clk) disable iff (reset)
		bus_a[A_CLK0] == bus_a[A_CLK1] && bus_a[A_CLK1] == bus_a_par)
		else $error("clock out copies differ");
	clk_alt_copy_a: assert property (@(posedge sys_clk) disable iff (reset)
		bus_a[A_CLK1B] == bus_a[A_CLK1]) else $error("clock out bit 5 differs");
	dout_copy_a: assert property (@(posedge sys_clk) disable iff (reset)
		bus_a[A_DOUT0] == bus_a[A_DOUT1] && bus_a[A_DOUT1] == bus_a[A_DOUT2])
		else $error("data out copies differ");
	maint_release_a: assert property (@(posedge link_clk) disable iff (reset)
		(ctl == CTL_MAINT) [*8] |-> !slv_drv_oe) else $error("drivers kept in maint");
	resetsel_drive_a: assert property (@(posedge link_clk) disable iff (reset)
		(ctl == CTL_RESETSEL1) [*8] |-> slv_drv_oe) else $error("drivers not restored");
	data_stable_a: assert property (@(posedge sys_clk) disable iff (reset)
		$changed(bus_a[A_DOUT2]) && bus_a[A_EOUT] |-> !bus_a[A_CLK0])
		else $error("data out moved while clock high");
	dir_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
		$rose(bus_a[A_CLK0]) && !bus_a[A_EOUT] |-> bus_a[A_DOUT2])
		else $error("direction pulse without data out");
	reset_enable_a: assert property (@(posedge sys_clk) disable iff (reset)
		$fell(sync_out) && bus_a[A_DOUT2] |-> bus_a[A_EOUT])
		else $error("reset request without enable out");
	resetsel_quiet_a: assert property (@(posedge sys_clk) disable iff (reset)
		ctl == CTL_RESETSEL1 |-> !bus_a[A_EOUT] && !bus_a[A_DOUT2])
		else $error("data or enable out high in resetsel");
endmodule // mms_link_checker

// ---- test/maintenance_mode_slave_test.sv ----
`timescale 1ns/10ps
module maintenance_mode_slave_test;
	import mms_pkg::*;
	localparam int W = 8;
	localparam int LIMIT = 20000;
	logic         sys_clk;
	logic         reset;
	logic         cmd_valid;
	mms_op_e      cmd_op;
	logic [W-1:0] cmd_data;
	logic         cmd_reset;
	logic         cmd_ready;
	logic         mm_data_in, mm_clk_in, mm_resp_in;
	logic         mm_reset, drv_released, maint_active, wr_valid;
	logic [W-1:0] wr_data, wr_last, wire_word;
	logic         rst_prev, clk_prev;
	int           wr_cnt, rst_cnt, num_errors, compares, cycles;

	mms_link_if mms_link_if_inst ();
	mms_master #(.DESER_WIDTH(W), .HALF_CYC(2), .STEP_CNT(8)) mms_master_inst (
		.reset(reset), .sys_clk(sys_clk), .link(mms_link_if_inst.master),
		.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
		.cmd_reset(cmd_reset), .cmd_ready(cmd_ready), .mm_data_in(mm_data_in),
		.mm_clk_in(mm_clk_in), .mm_resp_in(mm_resp_in));
	mms_slave #(.DESER_WIDTH(W), .MM2_EN(1'b1)) mms_slave_inst (
		.reset(reset), .sys_clk(sys_clk), .link(mms_link_if_inst.slave),
		.mm_reset(mm_reset), .drv_released(drv_released),
		.maint_active(maint_active), .wr_valid(wr_valid), .wr_data(wr_data));
	mms_link_checker mms_link_checker_inst (
		.sys_clk(sys_clk), .reset(reset), .link_clk(mms_link_if_inst.link_clk),
		.select_out(mms_link_if_inst.select_out),
		.master_out(mms_link_if_inst.master_out),
		.sync_out(mms_link_if_inst.sync_out), .bus_a(mms_link_if_inst.bus_a),
		.bus_a_par(mms_link_if_inst.bus_a_par),
		.slv_drv_oe(mms_link_if_inst.slv_drv_oe));

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// Monitor of slave outputs and of the outbound wire
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		rst_prev <= mm_reset;
		clk_prev <= mms_link_if_inst.bus_a[A_CLK0];
		if (wr_valid === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			wr_last <= wr_data;
		end
		if (mm_reset === 1'b1 && rst_prev === 1'b0) begin
			rst_cnt <= rst_cnt + 1;
		end
		if (mms_link_if_inst.bus_a[A_CLK0] && !clk_prev && mms_link_if_inst.bus_a[A_EOUT]) begin
			wire_word <= {wire_word[W-2:0], mms_link_if_inst.bus_a[A_DOUT2]};
		end
		if (cycles == LIMIT) begin
			num_errors++;
			end_of_test();
		end
	end

	task automatic wait_ready();
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 2000) begin
			@(negedge sys_clk);
			n++;
		end
	endtask

	task automatic send(input mms_op_e op, input logic [W-1:0] d, input logic r);
		wait_ready();
		@(posedge sys_clk);
		cmd_op <= op;
		cmd_data <= d;
		cmd_reset <= r;
		cmd_valid <= 1'b1;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		repeat (2) @(negedge sys_clk);
		wait_ready();
		check("cmd_ready", {8'h00, cmd_ready}, 9'h001);
		repeat (36) @(negedge sys_clk);
	endtask

	task automatic t_release();
		send(OP_MAINT, 8'h00, 1'b0);
		check("slv_drv_oe", {8'h00, mms_link_if_inst.slv_drv_oe}, 9'h000);
		check("drv_released", {8'h00, drv_released}, 9'h001);
		check("maint_active", {8'h00, maint_active}, 9'h001);
	endtask

	task automatic t_write(input logic [W-1:0] d);
		int n0;
		n0 = wr_cnt;
		send(OP_WRITE, d, 1'b0);
		check("wr_count", 9'(wr_cnt - n0), 9'h001);
		check("wr_data", {1'b0, wr_last}, {1'b0, d});
		check("wire_word", {1'b0, wire_word}, {1'b0, d});
	endtask

	task automatic t_reset();
		int n0;
		n0 = rst_cnt;
		send(OP_IDLE, 8'h00, 1'b1);
		check("reset_count", 9'(rst_cnt - n0), 9'h001);
		check("drv_released", {8'h00, drv_released}, 9'h001);
		send(OP_RESETSEL, 8'h00, 1'b0);
		check("mm_reset", {8'h00, mm_reset}, 9'h000);
		check("drv_released", {8'h00, drv_released}, 9'h000);
		check("slv_drv_oe", {8'h00, mms_link_if_inst.slv_drv_oe}, 9'h001);
		send(OP_NORMAL, 8'h00, 1'b0);
		check("maint_active", {8'h00, maint_active}, 9'h000);
	endtask

	task automatic t_noreset();
		int n0;
		n0 = rst_cnt;
		send(OP_MAINT, 8'h00, 1'b0);
		send(OP_IDLE, 8'h00, 1'b0);
		check("reset_count", 9'(rst_cnt - n0), 9'h000);
		check("drv_released", {8'h00, drv_released}, 9'h000);
		send(OP_NORMAL, 8'h00, 1'b0);
	endtask

	function automatic logic maj3(input logic a, input logic b, input logic c);
		return (a & b) | (a & c) | (b & c);
	endfunction

	task automatic t_inbound();
		logic [8:0] v [6];
		v = '{9'h090, 9'h002, 9'h148, 9'h124, 9'h040, 9'h1FF};
		foreach (v[i]) begin
			@(posedge sys_clk);
			mms_link_if_inst.bus_b <= v[i][7:0];
			mms_link_if_inst.bus_b_par <= v[i][8];
			repeat (12) @(negedge sys_clk);
			check("data_in", {8'h00, mm_data_in}, {8'h00, maj3(v[i][7], v[i][4], v[i][1])});
			check("clk_in", {8'h00, mm_clk_in}, {8'h00, v[i][6] & v[i][3]});
			check("resp_in", {8'h00, mm_resp_in}, {8'h00, maj3(v[i][5], v[i][2], v[i][8])});
		end
	endtask

	initial begin
		num_errors = 0;
		compares = 0;
		cycles = 0;
		wr_cnt = 0;
		rst_cnt = 0;
		reset = 1'b1;
		cmd_valid = 1'b0;
		cmd_op = OP_MAINT;
		cmd_data = '0;
		cmd_reset = 1'b0;
		mms_link_if_inst.bus_b = 8'h00;
		mms_link_if_inst.bus_b_par = 1'b0;
		repeat (6) @(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk);
		check("bus_a idle", {1'b0, mms_link_if_inst.bus_a}, 9'h000);
		t_release();
		t_write(8'hA5);
		t_write(8'h01);
		t_reset();
		t_noreset();
		t_inbound();
		end_of_test();
	end
endmodule // maintenance_mode_slave_test
